// File: rtl/ts_sample_pkg.sv
// Functional notes
// - Sample registers show the timestamp unit chosen by the unit pointer bit.
// - Nanoseconds register bit 30 reads 1 for rising edge, 0 for falling.
// - Nanoseconds register bits 29:0 hold the nanoseconds of the sample.
// - Seconds register holds all 32 bits of the sample seconds.
// - Three-bit phase tells which 8 ns slot of five in 40 ns.
// - Phase codes: 000=0, 001=8, 010=16, 011=24, 100=32 ns; others reserved.
// - Separate seventh and eighth records, read-only, reset to zero.
package ts_sample_pkg;
	localparam int ADDR_W = 12;
	localparam int NUM_UNITS = 2;
	localparam logic [11:0] OFS_S7_NS = 12'h59C;
	localparam logic [11:0] OFS_S7_SEC = 12'h5A0;
	localparam logic [11:0] OFS_S7_PHASE = 12'h5A4;
	localparam logic [11:0] OFS_S8_NS = 12'h5A8;
	localparam logic [11:0] OFS_S8_SEC = 12'h5AC;
	localparam logic [11:0] OFS_S8_PHASE = 12'h5B0;
	localparam int EDGE_BIT = 30;
	localparam int NS_W = 30;
	localparam int SEC_W = 32;
	localparam int PHASE_W = 3;
	localparam logic [31:0] RESET_VAL = 32'h00000000;
	localparam logic [2:0] PHASE_MAX = 3'h4;
	localparam int REC_W = 1 + NS_W + SEC_W + PHASE_W;
endpackage

// File: rtl/ts_sample_store.sv
`timescale 1ns/1ps
// Holds the captured records of one sample index for every timestamp unit
module ts_sample_store (
	input wire logic ref_clk, // Clock
	input wire logic nrst, // Sync reset, active low
	input wire logic wr_en, // Capture strobe
	input wire logic wr_unit, // Unit being captured
	input wire logic [ts_sample_pkg::REC_W-1:0] wr_rec, // Record in
	input wire logic rd_unit, // Unit being shown
	output logic [ts_sample_pkg::REC_W-1:0] rd_rec // Registered record out
);
	typedef struct packed {
		logic [ts_sample_pkg::NUM_UNITS-1:0][ts_sample_pkg::REC_W-1:0] mem;
		logic [ts_sample_pkg::REC_W-1:0] rd;
	} store_type;
	store_type st_ff, nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (wr_en) begin
			nxt_st.mem[wr_unit] = wr_rec;
		end
		nxt_st.rd = nxt_st.mem[rd_unit];
		if (!nrst) begin
			nxt_st = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		st_ff <= nxt_st;
	end

	assign rd_rec = st_ff.rd;
endmodule // ts_sample_store

// File: rtl/event_timestamp_sample_readout.sv
`timescale 1ns/1ps
module event_timestamp_sample_readout (
	input wire logic ref_clk, // 250 MHz clock
	input wire logic nrst, // Sync reset, active low
	input wire logic [ts_sample_pkg::ADDR_W-1:0] reg_addr, // Byte address
	input wire logic [31:0] reg_wdata, // Write data, ignored
	input wire logic reg_wr, // Write strobe
	input wire logic reg_rd, // Read strobe
	output logic [31:0] reg_rdata, // Read data, cycle after strobe
	input wire logic unit_pointer, // Unit index pointer bit
	input wire logic cap_valid, // Capture strobe from capture logic
	input wire logic cap_unit, // Unit that captured
	input wire logic cap_eighth, // 1 = eighth sample, 0 = seventh
	input wire logic cap_rising, // Captured edge was rising
	input wire logic [ts_sample_pkg::NS_W-1:0] cap_nanos, // Captured nanoseconds
	input wire logic [ts_sample_pkg::SEC_W-1:0] cap_secs, // Captured seconds
	input wire logic [ts_sample_pkg::PHASE_W-1:0] cap_phase // Captured slot phase
);
	localparam int NS_W = ts_sample_pkg::NS_W;
	localparam int SEC_W = ts_sample_pkg::SEC_W;
	localparam int PH_W = ts_sample_pkg::PHASE_W;
	localparam int REC_W = ts_sample_pkg::REC_W;

	// Field layout of one stored record, top bit first
	// The order must match the store's record width
	typedef struct packed {
		logic polarity;
		logic [NS_W-1:0] nanos;
		logic [SEC_W-1:0] secs;
		logic [PH_W-1:0] phase;
	} capture_rec_type;

	// Which register a read strobe addresses
	typedef enum {
		SEL_NONE,
		SEL_S7_NS,
		SEL_S7_SEC,
		SEL_S7_PHASE,
		SEL_S8_NS,
		SEL_S8_SEC,
		SEL_S8_PHASE
	} reg_sel_type;

	typedef struct packed {
		logic [31:0] rdata;
	} top_type;
	top_type st_ff, nxt_st;

	// One array entry per store, so each store output has a driver of its own
	logic [REC_W-1:0] rec_q [2];
	capture_rec_type cap_rec;
	logic [PH_W-1:0] safe_phase;
	capture_rec_type seventh_rec;
	capture_rec_type eighth_rec;
	reg_sel_type rd_sel;

	// Named fields of the records shown for the chosen unit
	logic seventh_capture_polarity;
	logic [NS_W-1:0] seventh_capture_nanos;
	logic [SEC_W-1:0] seventh_capture_secs;
	logic [PH_W-1:0] seventh_capture_slot_phase;
	logic eighth_capture_polarity;
	logic [NS_W-1:0] eighth_capture_nanos;
	logic [SEC_W-1:0] eighth_capture_secs;
	logic [PH_W-1:0] eighth_capture_slot_phase;

	// Register images
	logic [31:0] s7_ns_word;
	logic [31:0] s7_sec_word;
	logic [31:0] s7_ph_word;
	logic [31:0] s8_ns_word;
	logic [31:0] s8_sec_word;
	logic [31:0] s8_ph_word;

	// Reserved phase codes are forced to zero so software never sees them
	function automatic logic [2:0] legal_phase(input logic [2:0] code);
		legal_phase = (code > ts_sample_pkg::PHASE_MAX) ? 3'h0 : code;
	endfunction

	assign safe_phase = legal_phase(cap_phase);

	always_comb begin
		cap_rec = '0;
		cap_rec.polarity = cap_rising;
		cap_rec.nanos = cap_nanos;
		cap_rec.secs = cap_secs;
		cap_rec.phase = safe_phase;
	end

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_sample
			ts_sample_store u_store (
				.ref_clk(ref_clk),
				.nrst(nrst),
				.wr_en(cap_valid && (cap_eighth == 1'(g))),
				.wr_unit(cap_unit),
				.wr_rec(cap_rec),
				.rd_unit(unit_pointer),
				.rd_rec(rec_q[g])
			);
		end
	endgenerate

	// Unpack both records once so the register images read by field name
	assign seventh_rec = rec_q[0];
	assign eighth_rec = rec_q[1];

	assign seventh_capture_polarity = seventh_rec.polarity;
	assign seventh_capture_nanos = seventh_rec.nanos;
	assign seventh_capture_secs = seventh_rec.secs;
	assign seventh_capture_slot_phase = seventh_rec.phase;

	assign eighth_capture_polarity = eighth_rec.polarity;
	assign eighth_capture_nanos = eighth_rec.nanos;
	assign eighth_capture_secs = eighth_rec.secs;
	assign eighth_capture_slot_phase = eighth_rec.phase;

	// Bit 31 is reserved and always reads zero
	function automatic logic [31:0] ns_word(
		input logic rising,
		input logic [NS_W-1:0] nanos
	);
		ns_word = {1'b0, rising, nanos};
	endfunction

	function automatic logic [31:0] sec_word(
		input logic [SEC_W-1:0] secs
	);
		sec_word = secs;
	endfunction

	// Only the low three bits carry the slot; the rest is reserved
	function automatic logic [31:0] ph_word(
		input logic [PH_W-1:0] phase
	);
		ph_word = {29'h0000000, phase};
	endfunction

	// Only the exact word address of a register decodes; every other
	// address, including the upper bytes of a register, reads zero
	function automatic reg_sel_type decode_sel(
		input logic [ts_sample_pkg::ADDR_W-1:0] addr
	);
		decode_sel = SEL_NONE;
		unique case (addr)
			ts_sample_pkg::OFS_S7_NS: decode_sel = SEL_S7_NS;
			ts_sample_pkg::OFS_S7_SEC: decode_sel = SEL_S7_SEC;
			ts_sample_pkg::OFS_S7_PHASE: decode_sel = SEL_S7_PHASE;
			ts_sample_pkg::OFS_S8_NS: decode_sel = SEL_S8_NS;
			ts_sample_pkg::OFS_S8_SEC: decode_sel = SEL_S8_SEC;
			ts_sample_pkg::OFS_S8_PHASE: decode_sel = SEL_S8_PHASE;
			default: decode_sel = SEL_NONE;
		endcase
	endfunction

	assign rd_sel = decode_sel(reg_addr);

	assign s7_ns_word = ns_word(seventh_capture_polarity, seventh_capture_nanos);
	assign s7_sec_word = sec_word(seventh_capture_secs);
	assign s7_ph_word = ph_word(seventh_capture_slot_phase);
	assign s8_ns_word = ns_word(eighth_capture_polarity, eighth_capture_nanos);
	assign s8_sec_word = sec_word(eighth_capture_secs);
	assign s8_ph_word = ph_word(eighth_capture_slot_phase);

	// Writes are decoded nowhere: every register here is read-only, so
	// reg_wr and reg_wdata have no path into any state
	// Read data stand one cycle and then fall back to zero, so a late
	// sample of the bus never shows a stale word
	always_comb begin
		nxt_st = st_ff;
		nxt_st.rdata = ts_sample_pkg::RESET_VAL;
		if (reg_rd) begin
			unique case (rd_sel)
				SEL_S7_NS: nxt_st.rdata = s7_ns_word;
				SEL_S7_SEC: nxt_st.rdata = s7_sec_word;
				SEL_S7_PHASE: nxt_st.rdata = s7_ph_word;
				SEL_S8_NS: nxt_st.rdata = s8_ns_word;
				SEL_S8_SEC: nxt_st.rdata = s8_sec_word;
				SEL_S8_PHASE: nxt_st.rdata = s8_ph_word;
				SEL_NONE: nxt_st.rdata = ts_sample_pkg::RESET_VAL;
			endcase
		end
		if (!nrst) begin
			nxt_st.rdata = ts_sample_pkg::RESET_VAL;
		end
	end

	always_ff @(posedge ref_clk) begin
		st_ff <= nxt_st;
	end

	assign reg_rdata = st_ff.rdata;
endmodule // event_timestamp_sample_readout

// File: tb/ts_readout_monitor.sv
`timescale 1ns/1ps
module ts_readout_monitor (
	input wire logic ref_clk, // Clock
	input wire logic nrst, // Reset
	input wire logic [11:0] reg_addr, // Address
	input wire logic reg_wr, // Write
	input wire logic reg_rd, // Read
	input wire logic [31:0] reg_rdata, // Data
	input wire logic unit_pointer, // Unit
	input wire logic cap_valid, // Capture
	input wire logic cap_unit, // Source
	input wire logic cap_eighth, // Eighth
	input wire logic [31:0] cap_secs // Seconds
);
	logic [12:0] last_ff;
	always_ff @(posedge ref_clk) last_ff <= {reg_rd, reg_addr};
	wire ns = last_ff == 13'h159C || last_ff == 13'h15A8;
	wire ph = last_ff == 13'h15A4 || last_ff == 13'h15B0;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	a_idle_zero: assert property (!last_ff[12] |-> reg_rdata == '0) else $error("idle");
	a_ns_top: assert property (ns |-> !reg_rdata[31]) else $error("ns");
	a_ph_rsvd: assert property (ph |-> reg_rdata[31:3] == '0) else $error("phase");
	a_ph_code: assert property (ph |-> reg_rdata[2:0] <= 3'h4) else $error("code");
	a_top_unmapped: assert property (last_ff > 13'h15B0 |-> reg_rdata == '0) else $error("map");
	a_reset_zero: assert property ($rose(nrst) |-> reg_rdata == '0) else $error("rst");
	a_wr_quiet: assert property (reg_wr |=> reg_rdata == '0) else $error("wr");
	a_secs_path: assert property (cap_valid && !cap_eighth && cap_unit == unit_pointer ##1
		(!cap_valid && $stable(unit_pointer)) [*2] ##1 reg_rd && reg_addr == 12'h5A0
		&& $stable(unit_pointer) |=> reg_rdata == $past(cap_secs, 4)) else $error("secs");
endmodule // ts_readout_monitor
bind event_timestamp_sample_readout ts_readout_monitor u_ts_readout_monitor (.*);

// File: tb/tb.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	$display("Error reg_rdata at %h exp %h got %h", n, e, g); error_cnt++; end end
module tb;
	logic ref_clk = '0, nrst = '0, reg_wr = '0, reg_rd = '0, unit_pointer = '0;
	logic cap_valid = '0, cap_unit = '0, cap_eighth = '0, cap_rising = '0;
	logic [11:0] reg_addr = '0;
	logic [31:0] reg_wdata = '1, cap_secs = '0, reg_rdata;
	logic [29:0] cap_nanos = '0;
	logic [2:0] cap_phase = '0;
	int error_cnt = 0, cmp_count = 0;
	event_timestamp_sample_readout u_event_timestamp_sample_readout (.*);
	initial forever #2 ref_clk = ~ref_clk;
	// A write of ones before each read must not stick
	task rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge ref_clk) {reg_wr, reg_addr} <= {1'h1, a};
		@(posedge ref_clk) {reg_wr, reg_rd} <= 2'h1;
		@(posedge ref_clk) reg_rd <= '0;
		#1 `CHK(a, e, reg_rdata)
	endtask
	task cap(input logic [2:0] m, p, input logic [29:0] n, input logic [31:0] s);
		@(posedge ref_clk) {cap_valid, cap_unit, cap_eighth, cap_rising} <= {1'h1, m};
		{cap_phase, cap_nanos, cap_secs} <= {p, n, s};
		@(posedge ref_clk) cap_valid <= '0;
	endtask
	task end_of_test;
		if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge ref_clk);
		nrst <= '1;
		for (int i = 0; i < 7; i++) rd(12'h59C + 12'(4 * i), '0);
		cap(3'h1, 3'h3, '1, 32'hA5A5A5A5);
		rd(12'h5A0, 32'hA5A5A5A5);
		rd(12'h59C, 32'h7FFFFFFF);
		rd(12'h5A4, 32'h00000003);
		cap(3'h4, 3'h1, 30'h12345678, 32'h0F0F0F0F);
		rd(12'h5A0, 32'hA5A5A5A5);
		@(posedge ref_clk) unit_pointer <= '1;
		rd(12'h59C, 32'h12345678);
		rd(12'h5A0, 32'h0F0F0F0F);
		cap(3'h6, 3'h4, 30'h2AAAAAAA, 32'hC3C3C3C3);
		rd(12'h5A8, 32'h2AAAAAAA);
		rd(12'h5AC, 32'hC3C3C3C3);
		for (int i = 0; i < 8; i++) begin
			cap(3'h7, 3'(i), '0, '0);
			rd(12'h5B0, i < 5 ? 32'(i) : '0);
		end
		rd(12'h5A8, 32'h40000000);
		@(posedge ref_clk) unit_pointer <= '0;
		rd(12'h5AC, '0);
		// A reset in mid-run must clear captured records
		@(posedge ref_clk) nrst <= '0;
		repeat (6) @(posedge ref_clk);
		nrst <= '1;
		rd(12'h5A0, '0);
		rd(12'h59C, '0);
		end_of_test;
	end
endmodule // tb
